// ### verilog/panel_status_led_relay_ctrl.sv
// front-panel leds, ready beeper, reset button timing and alarm relay
`timescale 1ns/1ps
`default_nettype none
`include "panel_defs.svh"
module panel_status_led_relay_ctrl #(
	parameter int unsigned SLOW_HALF = `SLOW_HALF_CYC,
	parameter int unsigned FAST_HALF = `FAST_HALF_CYC,
	parameter int unsigned DEBOUNCE = `DEBOUNCE_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// power sources
	input wire logic supply1_ok,
	input wire logic supply2_ok,
	input wire logic poe_ok,
	// system status
	input wire logic dhcp_fail,
	input wire logic ip_conflict,
	input wire logic sys_failure,
	input wire logic user_event,
	input wire logic boot_failed,
	input wire logic sys_ready,
	// wireless status
	input wire logic wireless_ok,
	input wire logic wireless_ap_role,
	input wire logic wireless_traffic,
	// wired status
	input wire logic link_100,
	input wire logic link_10,
	input wire logic wired_traffic,
	// reset button, high while pressed
	input wire logic reset_button,
	// indicators
	output logic power_indicator_ff,
	output logic fault_indicator_ff,
	output logic state_green_ff,
	output logic wireless_indicator_green_ff,
	output logic wireless_indicator_amber_ff,
	output logic wired_port_indicator_green_ff,
	output logic wired_port_indicator_amber_ff,
	output logic beeper_ff,
	// button results, one-cycle pulses
	output logic reboot_req_ff,
	output logic factory_req_ff,
	// relay coil drive, high closes the contacts
	output logic relay_energise_ff
);
	logic [23:0] slow_cnt_ff;
	logic [23:0] fast_cnt_ff;
	logic slow_tick;
	logic fast_tick;
	logic slow_phase_ff;
	logic fast_phase_ff;
	logic btn_clean;
	logic [3:0] hold_sec_ff;
	logic long_ff;
	logic nxt_fault;
	logic nxt_wl_green;
	logic nxt_wl_amber;
	logic ready_d_ff;
	logic [1:0] beep_num_ff;
	panel_pkg::beep_state_e beep_st_ff;
	panel_pkg::btn_state_e btn_st_ff;

	// half-period counter step shared by the slow and fast counters
	function automatic logic [23:0] step_cnt(input logic [23:0] c,
			input int unsigned half);
		step_cnt = (c >= 24'(half - 1)) ? 24'h000000 : c + 24'h000001;
	endfunction

	assign slow_tick = (slow_cnt_ff == 24'(SLOW_HALF - 1));
	assign fast_tick = (fast_cnt_ff == 24'(FAST_HALF - 1));

	// separate slow and fast counters; each phase toggles at its half period
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			slow_cnt_ff <= 24'h000000;
			fast_cnt_ff <= 24'h000000;
			slow_phase_ff <= 1'b0;
			fast_phase_ff <= 1'b0;
		end else begin
			slow_cnt_ff <= step_cnt(slow_cnt_ff, SLOW_HALF);
			fast_cnt_ff <= step_cnt(fast_cnt_ff, FAST_HALF);
			if (slow_tick) begin
				slow_phase_ff <= ~slow_phase_ff;
			end
			if (fast_tick) begin
				fast_phase_ff <= ~fast_phase_ff;
			end
		end
	end

	// fault source priority: boot, conflict, server, failure
	always_comb begin
		if (boot_failed) begin
			nxt_fault = slow_phase_ff;
		end else if (ip_conflict) begin
			nxt_fault = fast_phase_ff;
		end else if (dhcp_fail) begin
			nxt_fault = slow_phase_ff;
		end else if (sys_failure || user_event) begin
			nxt_fault = 1'b1;
		end else begin
			nxt_fault = 1'b0;
		end
	end

	// wireless colour by role, blink with traffic
	always_comb begin
		nxt_wl_green = 1'b0;
		nxt_wl_amber = 1'b0;
		if (boot_failed) begin
			nxt_wl_green = slow_phase_ff;
		end else if (wireless_ok) begin
			if (wireless_ap_role) begin
				nxt_wl_amber = wireless_traffic ? fast_phase_ff : 1'b1;
			end else begin
				nxt_wl_green = wireless_traffic ? fast_phase_ff : 1'b1;
			end
		end
	end

	// registered indicator drive
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			power_indicator_ff <= 1'b0;
			fault_indicator_ff <= 1'b0;
			state_green_ff <= 1'b0;
			wireless_indicator_green_ff <= 1'b0;
			wireless_indicator_amber_ff <= 1'b0;
			wired_port_indicator_green_ff <= 1'b0;
			wired_port_indicator_amber_ff <= 1'b0;
		end else begin
			power_indicator_ff <= supply1_ok | supply2_ok | poe_ok;
			fault_indicator_ff <= nxt_fault;
			if (boot_failed) begin
				state_green_ff <= slow_phase_ff;
			end else if (long_ff) begin
				state_green_ff <= fast_phase_ff;
			end else begin
				state_green_ff <= 1'b0;
			end
			wireless_indicator_green_ff <= nxt_wl_green;
			wireless_indicator_amber_ff <= nxt_wl_amber;
			// 100 Mbit wins if both flags were ever raised together
			wired_port_indicator_green_ff <= link_100 &
				(wired_traffic ? fast_phase_ff : 1'b1);
			wired_port_indicator_amber_ff <= link_10 & ~link_100 &
				(wired_traffic ? fast_phase_ff : 1'b1);
		end
	end

	// relay: energised only when powered and quiet
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			relay_energise_ff <= 1'b0;
		end else begin
			relay_energise_ff <= (supply1_ok | supply2_ok | poe_ok) &
				~(sys_failure | user_event);
		end
	end

	panel_debounce #(
		.STABLE_CYC(DEBOUNCE)
	) u_debounce (
		.core_clk(core_clk),
		.resetn(resetn),
		.raw_in(reset_button),
		.clean_ff(btn_clean)
	);

	// hold timer in whole seconds of the shared slow base
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			btn_st_ff <= panel_pkg::BTN_IDLE;
			hold_sec_ff <= 4'h0;
			long_ff <= 1'b0;
			reboot_req_ff <= 1'b0;
			factory_req_ff <= 1'b0;
		end else begin
			reboot_req_ff <= 1'b0;
			factory_req_ff <= 1'b0;
			case (btn_st_ff)
				panel_pkg::BTN_IDLE: begin
					hold_sec_ff <= 4'h0;
					long_ff <= 1'b0;
					if (btn_clean) begin
						btn_st_ff <= panel_pkg::BTN_SHORT;
					end
				end
				panel_pkg::BTN_SHORT: begin
					if (!btn_clean) begin
						reboot_req_ff <= 1'b1;
						btn_st_ff <= panel_pkg::BTN_IDLE;
					end else if (slow_tick) begin
						// first second may be partial: one tick more
						// keeps the long hold beyond five seconds
						if (hold_sec_ff == 4'(`HOLD_LIMIT_S)) begin
							long_ff <= 1'b1;
							btn_st_ff <= panel_pkg::BTN_LONG;
						end else begin
							hold_sec_ff <= hold_sec_ff + 4'h1;
						end
					end
				end
				panel_pkg::BTN_LONG: begin
					if (!btn_clean) begin
						factory_req_ff <= 1'b1;
						long_ff <= 1'b0;
						btn_st_ff <= panel_pkg::BTN_IDLE;
					end
				end
				default: begin
					btn_st_ff <= panel_pkg::BTN_IDLE;
				end
			endcase
		end
	end

	// two short beeps on the rising edge of ready
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ready_d_ff <= 1'b0;
			beep_st_ff <= panel_pkg::BEEP_IDLE;
			beep_num_ff <= 2'h0;
			beeper_ff <= 1'b0;
		end else begin
			ready_d_ff <= sys_ready;
			case (beep_st_ff)
				panel_pkg::BEEP_IDLE: begin
					beep_num_ff <= 2'h0;
					if (sys_ready && !ready_d_ff) begin
						beep_st_ff <= panel_pkg::BEEP_WAIT;
					end
				end
				panel_pkg::BEEP_WAIT: begin
					// align to the fast base for equal beep lengths
					if (fast_tick) begin
						beeper_ff <= 1'b1;
						beep_st_ff <= panel_pkg::BEEP_ON;
					end
				end
				panel_pkg::BEEP_ON: begin
					if (fast_tick) begin
						beeper_ff <= 1'b0;
						beep_num_ff <= beep_num_ff + 2'h1;
						beep_st_ff <= panel_pkg::BEEP_GAP;
					end
				end
				panel_pkg::BEEP_GAP: begin
					if (fast_tick) begin
						if (beep_num_ff == 2'(`BEEP_COUNT)) begin
							beep_st_ff <= panel_pkg::BEEP_DONE;
						end else begin
							beeper_ff <= 1'b1;
							beep_st_ff <= panel_pkg::BEEP_ON;
						end
					end
				end
				panel_pkg::BEEP_DONE: begin
					// rearm only after ready drops
					if (!sys_ready) begin
						beep_st_ff <= panel_pkg::BEEP_IDLE;
					end
				end
				default: begin
					beep_st_ff <= panel_pkg::BEEP_IDLE;
				end
			endcase
		end
	end

	// checks
	a_power_follows: assert property (@(posedge core_clk) disable iff (!resetn)
		power_indicator_ff == $past(supply1_ok | supply2_ok | poe_ok))
		else $error("power led mismatch");
	a_fault_dark: assert property (@(posedge core_clk) disable iff (!resetn)
		(!boot_failed && !ip_conflict && !dhcp_fail && !sys_failure &&
		!user_event)[*2] |-> !fault_indicator_ff)
		else $error("fault led lit with no error");
	a_relay_opens: assert property (@(posedge core_clk) disable iff (!resetn)
		(sys_failure || user_event) |=> !relay_energise_ff)
		else $error("relay closed during event");
	a_relay_closed: assert property (@(posedge core_clk) disable iff (!resetn)
		((supply1_ok || supply2_ok || poe_ok) && !sys_failure && !user_event)
		|=> relay_energise_ff)
		else $error("relay not closed when quiet");
	a_wl_off: assert property (@(posedge core_clk) disable iff (!resetn)
		(!wireless_ok && !boot_failed) |=> !wireless_indicator_green_ff &&
		!wireless_indicator_amber_ff)
		else $error("wireless led lit while unused");
	a_wl_amber: assert property (@(posedge core_clk) disable iff (!resetn)
		(wireless_ok && wireless_ap_role && !wireless_traffic && !boot_failed)
		|=> wireless_indicator_amber_ff && !wireless_indicator_green_ff)
		else $error("ap role not amber");
	a_wl_green: assert property (@(posedge core_clk) disable iff (!resetn)
		(wireless_ok && !wireless_ap_role && !wireless_traffic && !boot_failed)
		|=> wireless_indicator_green_ff && !wireless_indicator_amber_ff)
		else $error("client role not green");
	a_wired_green: assert property (@(posedge core_clk) disable iff (!resetn)
		(link_100 && !wired_traffic) |=> wired_port_indicator_green_ff)
		else $error("100 link led dark");
	a_wired_amber: assert property (@(posedge core_clk) disable iff (!resetn)
		!link_10 |=> !wired_port_indicator_amber_ff)
		else $error("amber lit without 10 link");
	a_conflict_fast: assert property (@(posedge core_clk) disable iff (!resetn)
		(ip_conflict && !boot_failed) |=> fault_indicator_ff ==
		$past(fast_phase_ff))
		else $error("conflict not fast blink");
	a_factory_long: assert property (@(posedge core_clk) disable iff (!resetn)
		factory_req_ff |-> $past(long_ff))
		else $error("factory reset without long hold");
	a_reboot_short: assert property (@(posedge core_clk) disable iff (!resetn)
		reboot_req_ff |-> !$past(long_ff) && !btn_clean)
		else $error("reboot after long hold");

	// multi-step checks for the beeper and the hold timer
	sequence s_beep_idle;
		beep_st_ff == panel_pkg::BEEP_IDLE;
	endsequence
	sequence s_ready_rise;
		sys_ready && !ready_d_ff;
	endsequence
	sequence s_beep_start;
		$rose(beeper_ff);
	endsequence
	sequence s_long_set;
		$rose(long_ff);
	endsequence
	a_beep_arms: assert property (@(posedge core_clk) disable iff (!resetn)
		s_beep_idle ##0 s_ready_rise |=>
		beep_st_ff == panel_pkg::BEEP_WAIT)
		else $error("beeper not armed on ready");
	a_beep_two: assert property (@(posedge core_clk) disable iff (!resetn)
		s_beep_start |-> $past(beep_num_ff) < 2'(`BEEP_COUNT))
		else $error("more than two beeps");
	a_long_after_five: assert property (@(posedge core_clk)
		disable iff (!resetn)
		s_long_set |-> $past(hold_sec_ff) == 4'(`HOLD_LIMIT_S))
		else $error("long hold flagged early");
endmodule
`default_nettype wire

// ### verilog/panel_defs.svh
// timing constants for the front-panel status logic
`ifndef PANEL_DEFS_SVH
`define PANEL_DEFS_SVH
`define CLK_HZ 10000000
`define SLOW_HALF_MS 1000
`define FAST_HALF_MS 500
`define SLOW_HALF_CYC ((`CLK_HZ / 1000) * `SLOW_HALF_MS)
`define FAST_HALF_CYC ((`CLK_HZ / 1000) * `FAST_HALF_MS)
`define HOLD_LIMIT_S 5
`define DEBOUNCE_MS 20
`define DEBOUNCE_CYC ((`CLK_HZ / 1000) * `DEBOUNCE_MS)
`define BEEP_MS 100
`define BEEP_TICKS 2
`define BEEP_COUNT 2
`endif

// ### verilog/panel_pkg.sv
// types for the front-panel status logic
package panel_pkg;
	typedef enum logic [4:0] {
		BEEP_IDLE = 5'h01,
		BEEP_ON = 5'h02,
		BEEP_GAP = 5'h04,
		BEEP_DONE = 5'h08,
		BEEP_WAIT = 5'h10
	} beep_state_e;
	typedef enum logic [2:0] {
		BTN_IDLE = 3'h1,
		BTN_SHORT = 3'h2,
		BTN_LONG = 3'h4
	} btn_state_e;
endpackage

// ### verilog/panel_debounce.sv
// debounce filter for the reset button
`timescale 1ns/1ps
`default_nettype none
`include "panel_defs.svh"
module panel_debounce #(
	parameter int unsigned STABLE_CYC = `DEBOUNCE_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// raw and filtered level
	input wire logic raw_in,
	output logic clean_ff
);
	logic [17:0] cnt_ff;
	// accept a new level only after it has held steady
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_ff <= 18'h00000;
			clean_ff <= 1'b0;
		end else if (raw_in == clean_ff) begin
			cnt_ff <= 18'h00000;
		end else if (cnt_ff >= 18'(STABLE_CYC - 1)) begin
			cnt_ff <= 18'h00000;
			clean_ff <= raw_in;
		end else begin
			cnt_ff <= cnt_ff + 18'h00001;
		end
	end
endmodule
`default_nettype wire

// ### test/panel_button_model.sv
// operator model pressing and releasing the reset button
`timescale 1ns/1ps
`default_nettype none
module panel_button_model (
	// clock
	input wire logic core_clk,
	// button level, high while pressed
	output logic reset_button
);
	initial reset_button = 1'b0;
	// press held in whole cycles, changed just after an edge
	task automatic push();
		@(posedge core_clk);
		reset_button <= 1'b1;
	endtask
	task automatic let_go();
		@(posedge core_clk);
		reset_button <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the front-panel status logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic core_clk;
	logic resetn;
	// 0 s1,1 s2,2 poe,3 dhcp,4 conflict,5 fail,6 event,7 boot,8 ready
	// 9 wl ok,10 ap,11 wl traffic,12 l100,13 l10,14 wired traffic
	logic [14:0] stim;
	wire rst_btn;
	wire [10:0] obs;
	int eg[11];
	int hi[11];
	int split;
	int num_errors = 0;
	int checks_done = 0;
	// shortened counts keep the run small
	panel_status_led_relay_ctrl #(.SLOW_HALF(20), .FAST_HALF(10),
		.DEBOUNCE(3)) i_panel_status_led_relay_ctrl (
		.core_clk(core_clk), .resetn(resetn),
		.supply1_ok(stim[0]), .supply2_ok(stim[1]), .poe_ok(stim[2]),
		.dhcp_fail(stim[3]), .ip_conflict(stim[4]),
		.sys_failure(stim[5]), .user_event(stim[6]),
		.boot_failed(stim[7]), .sys_ready(stim[8]),
		.wireless_ok(stim[9]), .wireless_ap_role(stim[10]),
		.wireless_traffic(stim[11]), .link_100(stim[12]),
		.link_10(stim[13]), .wired_traffic(stim[14]),
		.reset_button(rst_btn),
		.power_indicator_ff(obs[0]), .fault_indicator_ff(obs[1]),
		.state_green_ff(obs[2]), .wireless_indicator_green_ff(obs[3]),
		.wireless_indicator_amber_ff(obs[4]),
		.wired_port_indicator_green_ff(obs[5]),
		.wired_port_indicator_amber_ff(obs[6]), .beeper_ff(obs[7]),
		.reboot_req_ff(obs[8]), .factory_req_ff(obs[9]),
		.relay_energise_ff(obs[10]));
	panel_button_model i_panel_button_model (
		.core_clk(core_clk), .reset_button(rst_btn));
	// 100 ns period
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	task automatic chk(input string nm, input int e, input int g);
		checks_done++;
		if (e != g) begin
			$display("MISMATCH %s expected %0d seen %0d", nm, e, g);
			num_errors++;
		end
	endtask
	// counts toggles and lit cycles of every output over n cycles
	task automatic watch(input int n);
		logic [10:0] prev;
		for (int i = 0; i < 11; i++) begin
			eg[i] = 0;
			hi[i] = 0;
		end
		split = 0;
		@(posedge core_clk);
		#1 prev = obs;
		repeat (n) begin
			@(posedge core_clk);
			#1;
			for (int i = 0; i < 11; i++) begin
				if (obs[i] !== prev[i]) eg[i]++;
				if (obs[i] === 1'b1) hi[i]++;
			end
			if (obs[1] !== obs[2] || obs[1] !== obs[3]) split++;
			prev = obs;
		end
	endtask
	// 80 cycles hold two slow or four fast periods
	task automatic look(input string nm, input logic [14:0] v,
		input int idx, input int e, input int h);
		@(posedge core_clk);
		stim <= v;
		repeat (3) @(posedge core_clk);
		watch(80);
		chk({nm, " toggles"}, e, eg[idx]);
		chk({nm, " lit"}, h, hi[idx]);
	endtask
	task automatic t_power();
		look("power none", 15'h0000, 0, 0, 0);
		look("relay none", 15'h0000, 10, 0, 0);
		look("power s1", 15'h0001, 0, 0, 80);
		look("power s2", 15'h0002, 0, 0, 80);
		look("power poe", 15'h0004, 0, 0, 80);
		look("relay idle", 15'h0004, 10, 0, 80);
		look("relay fail", 15'h0021, 10, 0, 0);
		look("relay event", 15'h0041, 10, 0, 0);
		look("fault event", 15'h0041, 1, 0, 80);
		look("fault fail", 15'h0021, 1, 0, 80);
	endtask
	task automatic t_fault();
		look("fault clear", 15'h0001, 1, 0, 0);
		look("fault dhcp", 15'h0009, 1, 4, 40);
		look("fault clash", 15'h0011, 1, 8, 40);
		look("fault both", 15'h0019, 1, 8, 40);
	endtask
	task automatic t_wireless();
		look("wl green", 15'h0201, 3, 0, 80);
		look("wl green amber", 15'h0201, 4, 0, 0);
		look("wl green data", 15'h0A01, 3, 8, 40);
		look("wl amber", 15'h0601, 4, 0, 80);
		look("wl amber green", 15'h0601, 3, 0, 0);
		look("wl amber data", 15'h0E01, 4, 8, 40);
		look("wl off amber", 15'h0C01, 4, 0, 0);
		look("wl off green", 15'h0801, 3, 0, 0);
	endtask
	task automatic t_wired();
		look("lan green", 15'h1001, 5, 0, 80);
		look("lan green data", 15'h5001, 5, 8, 40);
		look("lan amber", 15'h2001, 6, 0, 80);
		look("lan amber green", 15'h2001, 5, 0, 0);
		look("lan amber data", 15'h6001, 6, 8, 40);
		look("lan off", 15'h4001, 6, 0, 0);
	endtask
	task automatic t_boot();
		look("boot fault", 15'h0081, 1, 4, 40);
		chk("boot state", 4, eg[2]);
		chk("boot wireless", 4, eg[3]);
		chk("boot unison", 0, split);
	endtask
	task automatic t_beep();
		@(posedge core_clk);
		stim <= 15'h0101;
		watch(100);
		chk("beep toggles", 4, eg[7]);
		chk("beep lit", 20, hi[7]);
	endtask
	task automatic t_button();
		i_panel_button_model.push();
		i_panel_button_model.let_go();
		watch(20);
		chk("glitch reboot", 0, hi[8]);
		i_panel_button_model.push();
		repeat (60) @(posedge core_clk);
		i_panel_button_model.let_go();
		watch(20);
		chk("short reboot", 1, hi[8]);
		chk("short factory", 0, hi[9]);
		// no blink before 5 s (100 cycles), blinking by 6 s
		i_panel_button_model.push();
		repeat (80) @(posedge core_clk);
		watch(20);
		chk("long early", 0, eg[2]);
		repeat (19) @(posedge core_clk);
		watch(40);
		chk("long state blink", 1, int'(eg[2] > 0));
		i_panel_button_model.let_go();
		watch(20);
		chk("long factory", 1, hi[9]);
		chk("long reboot", 0, hi[8]);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// cuts a hang well past the expected 3000 cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		results();
	end
	initial begin
		resetn = 1'b0;
		stim = 15'h0000;
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		t_power();
		t_fault();
		t_wireless();
		t_wired();
		t_boot();
		t_beep();
		t_button();
		results();
	end
endmodule
`default_nettype wire
